// file: design/mrpl_latch.sv
// one storage protection latch with one address region
// assumes init is a registered level from the reset orchestrator
`timescale 1ns/100ps
module mrpl_latch
  import mrpl_pkg::*;
(
  input wire logic clk,
  input wire logic init,
  input wire logic activate,
  input wire logic cfg_we,
  input mrpl_cfg_t cfg_wdata,
  input wire logic [7:0] acc_addr,
  output logic active,
  output mrpl_cfg_t cfg,
  output logic blk_rd,
  output logic blk_wr
);
  // no clear path other than init
  always_ff @(posedge clk or posedge init) begin
    if (init) begin
      active <= 1'b0;
    end else if (activate) begin
      active <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge init) begin
    if (init) begin
      cfg <= CFG_RST;
    end else if (cfg_we && (!active || cfg_grows(cfg, cfg_wdata))) begin
      cfg <= cfg_wdata;
    end
  end

  always_comb begin
    blk_rd = active && in_rgn(cfg, acc_addr) && mode_rd(cfg.mode);
    blk_wr = active && in_rgn(cfg, acc_addr) && mode_wr(cfg.mode);
  end

  a_act_sticky: assert property (@(posedge clk) disable iff (init)
    active |=> active) else $error("latch left active without init");
  a_init_clears: assert property (@(posedge clk)
    init && $past(init) |-> !active && cfg == CFG_RST) else $error("init did not clear latch");
  a_cfg_grow: assert property (@(posedge clk) disable iff (init)
    active && $past(active) && cfg != $past(cfg) |-> cfg_grows($past(cfg), cfg))
    else $error("active latch lost protection");
  a_mode_codes: assert property (@(posedge clk) disable iff (init)
    !(cfg.mode == MODE_BLK_WR && blk_rd) && !(cfg.mode == MODE_BLK_RD && blk_wr))
    else $error("mode code blocks the wrong access");
endmodule : mrpl_latch

// file: design/mrpl_top.sv
// module reset orchestrator with storage protection latches
// assumes ACCESS_SEE marks register requests that come from the secure environment
//
// The placing of the registers and the strobed register port were decided locally.
`timescale 1ns/100ps
module mrpl_top
  import mrpl_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic [AW-1:0] ADDR,
  input wire logic [DW-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic ACCESS_SEE,
  output logic [DW-1:0] RDATA,
  input wire logic WDOG_ATTN,
  input wire logic [7:0] STG_ADDR,
  input wire logic STG_RD,
  input wire logic STG_WR,
  output logic STG_RD_OK,
  output logic STG_WR_OK,
  output logic STG_BLOCKED,
  output logic INIT_OUT,
  output logic SEE_ACTIVE,
  output logic SEE_PROTECT,
  output logic RE_RUN,
  output logic RT_RUN,
  output logic BUSM_EN
);
  mrpl_state_t state;
  mrpl_state_t next_state;
  mrpl_cause_t cause;
  mrpl_cause_t next_cause;
  logic [1:0] init_cnt;
  logic init_q;
  logic blk_seen;
  logic trig;
  logic wr_ctrl;
  logic wr_status;
  logic wr_act;
  logic sw_rst;
  logic re_done;
  logic any_blk_rd;
  logic any_blk_wr;
  logic any_wr_prot;
  logic [NLATCH-1:0] act;
  logic [NLATCH-1:0] cfg_we;
  logic [NLATCH-1:0] lat_active;
  logic [NLATCH-1:0] lat_blk_rd;
  logic [NLATCH-1:0] lat_blk_wr;
  mrpl_cfg_t lat_cfg [NLATCH];
  mrpl_cfg_t cfg_wdata;

  // register offset match for the configuration word of latch n
  function automatic logic cfg_ofs_hit(input logic [AW-1:0] a, input int n);
    cfg_ofs_hit = (a == OFS_CFG0 + AW'(n) * OFS_CFG_STEP);
  endfunction : cfg_ofs_hit

  assign cfg_wdata = mrpl_cfg_t'(WDATA[CFG_MODE_LSB+1:CFG_LO_LSB]);
  assign wr_ctrl = WR && (ADDR == OFS_CTRL);
  assign wr_status = WR && (ADDR == OFS_STATUS);
  assign wr_act = WR && (ADDR == OFS_ACT);

  // runtime may only ask for a reset once it owns the module
  assign sw_rst = wr_ctrl && WDATA[CTRL_SWRST] && (ACCESS_SEE || state == ST_RT);
  // release needs at least one active write-blocking latch in place
  assign re_done = wr_ctrl && WDATA[CTRL_RE_DONE] && ACCESS_SEE && state == ST_RE
    && any_wr_prot;
  assign trig = WDOG_ATTN || sw_rst;

  always_comb begin
    next_state = state;
    next_cause = cause;
    if (trig) begin
      next_state = ST_INIT;
      next_cause = WDOG_ATTN ? CAUSE_WDOG : CAUSE_PROG;
    end else begin
      case (state)
        ST_INIT: begin
          if (init_cnt == INIT_LAST) begin
            next_state = ST_SEE;
          end
        end
        ST_SEE: begin
          next_state = ST_RE;
        end
        ST_RE: begin
          if (re_done) begin
            next_state = ST_RT;
          end
        end
        ST_RT: begin
          next_state = ST_RT;
        end
        default: begin
          next_state = ST_INIT;
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      state <= ST_INIT;
      cause <= CAUSE_POR;
    end else begin
      state <= next_state;
      cause <= next_cause;
    end
  end

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      init_cnt <= 2'h0;
    end else if (trig || state != ST_INIT) begin
      init_cnt <= 2'h0;
    end else begin
      init_cnt <= init_cnt + 2'h1;
    end
  end

  // the only driver of initialize is the orchestrator state
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      init_q <= 1'b1;
      INIT_OUT <= 1'b1;
    end else begin
      init_q <= (next_state == ST_INIT);
      INIT_OUT <= (next_state == ST_INIT);
    end
  end

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      SEE_ACTIVE <= 1'b0;
      SEE_PROTECT <= 1'b1;
      RE_RUN <= 1'b0;
      RT_RUN <= 1'b0;
    end else begin
      SEE_ACTIVE <= (next_state != ST_INIT);
      SEE_PROTECT <= (next_state != ST_RT);
      RE_RUN <= (next_state == ST_RE);
      RT_RUN <= (next_state == ST_RT);
    end
  end

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      BUSM_EN <= 1'b0;
    end else if (next_state == ST_INIT) begin
      BUSM_EN <= 1'b0;
    end else if (wr_ctrl && ACCESS_SEE) begin
      BUSM_EN <= WDATA[CTRL_BUSM];
    end
  end

  always_comb begin
    for (int i = 0; i < NLATCH; i++) begin
      act[i] = wr_act && WDATA[i];
      cfg_we[i] = WR && cfg_ofs_hit(ADDR, i);
    end
  end

  for (genvar g = 0; g < NLATCH; g++) begin : g_latch
    mrpl_latch u_latch (
      .clk(REF_CLK),
      .init(init_q),
      .activate(act[g]),
      .cfg_we(cfg_we[g]),
      .cfg_wdata(cfg_wdata),
      .acc_addr(STG_ADDR),
      .active(lat_active[g]),
      .cfg(lat_cfg[g]),
      .blk_rd(lat_blk_rd[g]),
      .blk_wr(lat_blk_wr[g])
    );
  end

  always_comb begin
    any_blk_rd = |lat_blk_rd;
    any_blk_wr = |lat_blk_wr;
    any_wr_prot = 1'b0;
    for (int i = 0; i < NLATCH; i++) begin
      any_wr_prot = any_wr_prot || (lat_active[i] && mode_wr(lat_cfg[i].mode));
    end
  end

  // grants lag the request by one cycle so they come from flops
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      STG_RD_OK <= 1'b0;
      STG_WR_OK <= 1'b0;
      STG_BLOCKED <= 1'b0;
    end else begin
      STG_RD_OK <= STG_RD && !any_blk_rd;
      STG_WR_OK <= STG_WR && !any_blk_wr;
      STG_BLOCKED <= (STG_RD && any_blk_rd) || (STG_WR && any_blk_wr);
    end
  end

  // sticky copy of the attention; a new block wins over a clear
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      blk_seen <= 1'b0;
    end else if ((STG_RD && any_blk_rd) || (STG_WR && any_blk_wr)) begin
      blk_seen <= 1'b1;
    end else if (init_q || (wr_status && WDATA[STS_BLK])) begin
      blk_seen <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      RDATA <= '0;
    end else if (!RD) begin
      RDATA <= '0;
    end else begin
      RDATA <= '0;
      case (ADDR)
        OFS_CTRL: begin
          RDATA[CTRL_BUSM] <= BUSM_EN;
        end
        OFS_STATUS: begin
          RDATA[STS_STATE_LSB+1:STS_STATE_LSB] <= state;
          RDATA[STS_BUSM] <= BUSM_EN;
          RDATA[STS_BLK] <= blk_seen;
          RDATA[STS_SEE] <= SEE_ACTIVE;
          RDATA[STS_RT] <= RT_RUN;
        end
        OFS_CAUSE: begin
          if (ACCESS_SEE) begin
            RDATA[1:0] <= cause;
          end
        end
        OFS_ACT: begin
          RDATA[NLATCH-1:0] <= lat_active;
        end
        default: begin
          for (int i = 0; i < NLATCH; i++) begin
            if (cfg_ofs_hit(ADDR, i)) begin
              RDATA[CFG_MODE_LSB+1:CFG_LO_LSB] <= lat_cfg[i];
            end
          end
        end
      endcase
    end
  end

  a_init_source: assert property (@(posedge REF_CLK) disable iff (RESET)
    $rose(init_q) |-> $past(trig)) else $error("initialize raised without module reset");
  a_init_width: assert property (@(posedge REF_CLK) disable iff (RESET)
    $rose(init_q) && !trig |=> init_q ##1 !init_q || trig)
    else $error("initialize pulse has wrong length");
  a_see_first: assert property (@(posedge REF_CLK) disable iff (RESET)
    $rose(RE_RUN) |-> $past(SEE_ACTIVE) && !RT_RUN)
    else $error("recovery engine ran before secure setup");
  a_re_before_rt: assert property (@(posedge REF_CLK) disable iff (RESET)
    $rose(RT_RUN) |-> $past(RE_RUN)) else $error("runtime launched before recovery engine");
  a_rt_no_intr: assert property (@(posedge REF_CLK) disable iff (RESET)
    state == ST_RE && !ACCESS_SEE && !WDOG_ATTN |=> state != ST_INIT)
    else $error("runtime interrupted the recovery engine");
  a_busm_held: assert property (@(posedge REF_CLK) disable iff (RESET)
    init_q |-> !BUSM_EN) else $error("bus master enabled during initialize");
  a_cause_hidden: assert property (@(posedge REF_CLK) disable iff (RESET)
    RD && !ACCESS_SEE && ADDR == OFS_CAUSE |=> RDATA == '0)
    else $error("reset cause visible outside secure environment");
  a_wr_block: assert property (@(posedge REF_CLK) disable iff (RESET)
    STG_WR && any_blk_wr |=> !STG_WR_OK && STG_BLOCKED) else $error("blocked write granted");
  a_rd_block: assert property (@(posedge REF_CLK) disable iff (RESET)
    STG_RD && |lat_blk_rd |=> !STG_RD_OK) else $error("covered read granted");
  a_wp_first: assert property (@(posedge REF_CLK) disable iff (RESET)
    $rose(RT_RUN) |-> $past(any_wr_prot)) else $error("runtime launched without write protect");
  a_init_follows: assert property (@(posedge REF_CLK) disable iff (RESET)
    trig |=> INIT_OUT && !RE_RUN && !RT_RUN) else $error("module reset left blocks running");
  a_blk_sticky: assert property (@(posedge REF_CLK) disable iff (RESET)
    (STG_RD && any_blk_rd) || (STG_WR && any_blk_wr) |=> blk_seen)
    else $error("blocked access not recorded");

  c_reach_rt: cover property (@(posedge REF_CLK) disable iff (RESET) $rose(RT_RUN));
  c_blocked: cover property (@(posedge REF_CLK) disable iff (RESET) STG_BLOCKED);
  c_sw_reset: cover property (@(posedge REF_CLK) disable iff (RESET) state == ST_RT && sw_rst);
  c_wdog_reset: cover property (@(posedge REF_CLK) disable iff (RESET) RT_RUN && WDOG_ATTN);
endmodule : mrpl_top

// file: include/mrpl_pkg.sv
// constants, types and helpers for the module reset and protection latch block
// assumes one clock domain and an 8-bit byte-offset register port
package mrpl_pkg;
  localparam int AW = 8;
  localparam int DW = 32;
  localparam int NLATCH = 2;
  localparam logic [1:0] INIT_CYCLES = 2'h2;
  localparam logic [1:0] INIT_LAST = INIT_CYCLES - 2'h1;

  localparam logic [AW-1:0] OFS_CTRL = 8'h00;
  localparam logic [AW-1:0] OFS_STATUS = 8'h04;
  localparam logic [AW-1:0] OFS_CAUSE = 8'h08;
  localparam logic [AW-1:0] OFS_ACT = 8'h0C;
  localparam logic [AW-1:0] OFS_CFG0 = 8'h10;
  localparam logic [AW-1:0] OFS_CFG_STEP = 8'h04;

  localparam int CTRL_RE_DONE = 0;
  localparam int CTRL_BUSM = 1;
  localparam int CTRL_SWRST = 2;

  localparam int STS_STATE_LSB = 0;
  localparam int STS_BUSM = 4;
  localparam int STS_BLK = 5;
  localparam int STS_SEE = 6;
  localparam int STS_RT = 7;

  localparam int CFG_LO_LSB = 0;
  localparam int CFG_HI_LSB = 8;
  localparam int CFG_MODE_LSB = 16;
  localparam logic [1:0] MODE_BLK_RD = 2'h0;
  localparam logic [1:0] MODE_BLK_WR = 2'h1;
  localparam logic [1:0] MODE_BLK_RW = 2'h2;

  typedef enum logic [1:0] {
    CAUSE_NONE = 2'h0,
    CAUSE_POR = 2'h1,
    CAUSE_WDOG = 2'h2,
    CAUSE_PROG = 2'h3
  } mrpl_cause_t;

  typedef enum logic [1:0] {
    ST_INIT = 2'h0,
    ST_SEE = 2'h1,
    ST_RE = 2'h2,
    ST_RT = 2'h3
  } mrpl_state_t;

  typedef struct packed {
    logic [1:0] mode;
    logic [7:0] rgn_hi;
    logic [7:0] rgn_lo;
  } mrpl_cfg_t;

  // lo above hi is an empty region, so a fresh latch covers nothing
  localparam mrpl_cfg_t CFG_RST = '{mode: MODE_BLK_WR, rgn_hi: 8'h00, rgn_lo: 8'hFF};

  function automatic logic mode_rd(input logic [1:0] m);
    mode_rd = (m == MODE_BLK_RD) || (m == MODE_BLK_RW);
  endfunction : mode_rd

  function automatic logic mode_wr(input logic [1:0] m);
    mode_wr = (m == MODE_BLK_WR) || (m == MODE_BLK_RW);
  endfunction : mode_wr

  function automatic logic in_rgn(input mrpl_cfg_t c, input logic [7:0] a);
    in_rgn = (a >= c.rgn_lo) && (a <= c.rgn_hi);
  endfunction : in_rgn

  // new setting keeps every block the old one had
  function automatic logic cfg_grows(input mrpl_cfg_t o, input mrpl_cfg_t n);
    logic empty;
    empty = o.rgn_lo > o.rgn_hi;
    cfg_grows = (empty || (n.rgn_lo <= o.rgn_lo && n.rgn_hi >= o.rgn_hi))
      && (!mode_rd(o.mode) || mode_rd(n.mode)) && (!mode_wr(o.mode) || mode_wr(n.mode))
      && (n.mode != 2'h3);
  endfunction : cfg_grows
endpackage : mrpl_pkg

// file: sim/mrpl_stg_master.sv
// storage-side bus master model for the protection latch block
// assumes grants and the blocked pulse answer one cycle after a request
`timescale 1ns/100ps
module mrpl_stg_master
  import mrpl_pkg::*;
(
  input wire logic clk,
  output logic [7:0] stg_addr,
  output logic stg_rd,
  output logic stg_wr,
  input wire logic rd_ok,
  input wire logic wr_ok,
  input wire logic blocked
);
  initial begin
    stg_addr = 8'h00;
    stg_rd = 1'b0;
    stg_wr = 1'b0;
  end

  // asks for read and write together so both grants are always meaningful
  task automatic access(input logic [7:0] a, output logic [2:0] res);
    @(posedge clk);
    stg_addr <= a;
    stg_rd <= 1'b1;
    stg_wr <= 1'b1;
    @(posedge clk);
    stg_rd <= 1'b0;
    stg_wr <= 1'b0;
    // released address shows the inverse so a stale value cannot pass
    stg_addr <= ~a;
    #1 res = {rd_ok, wr_ok, blocked};
  endtask : access
endmodule : mrpl_stg_master

// file: sim/mrpl_top_bench.sv
// self-checking bench for the reset orchestrator and protection latches
// assumes the storage master model drives the storage port
`timescale 1ns/100ps
module mrpl_top_bench
  import mrpl_pkg::*;
();
  typedef struct packed {
    logic [7:0] a;
    logic [2:0] exp;
  } mrpl_row_t;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [AW-1:0] addr = 8'h00;
  logic [DW-1:0] wdata = 32'h0;
  logic wr = 1'b0, rd = 1'b0, see = 1'b0, wdog = 1'b0;
  logic [DW-1:0] rdata, v;
  logic [7:0] stg_addr;
  logic stg_rd, stg_wr, rok, wok, blk;
  logic init_out, see_act, see_prot, re_run, rt_run, busm;
  wire logic [5:0] ov;
  int fail_count = 0;
  int total_checks = 0;
  int i;
  // latch0 10..1F blocks writes, latch1 18..27 blocks reads; {rd_ok, wr_ok, blocked}
  mrpl_row_t rows [8] = '{'{8'h08, 3'b110}, '{8'h10, 3'b101}, '{8'h12, 3'b101},
    '{8'h1C, 3'b001}, '{8'h1F, 3'b001}, '{8'h24, 3'b011}, '{8'h27, 3'b011}, '{8'h28, 3'b110}};

  assign ov = {init_out, see_prot, see_act, re_run, rt_run, busm};
  always #4 ref_clk = ~ref_clk;

  mrpl_top uut (.REF_CLK(ref_clk), .RESET(reset), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .ACCESS_SEE(see), .RDATA(rdata), .WDOG_ATTN(wdog), .STG_ADDR(stg_addr),
    .STG_RD(stg_rd), .STG_WR(stg_wr), .STG_RD_OK(rok), .STG_WR_OK(wok),
    .STG_BLOCKED(blk), .INIT_OUT(init_out), .SEE_ACTIVE(see_act),
    .SEE_PROTECT(see_prot), .RE_RUN(re_run), .RT_RUN(rt_run), .BUSM_EN(busm));
  mrpl_stg_master stg (.clk(ref_clk), .stg_addr(stg_addr), .stg_rd(stg_rd),
    .stg_wr(stg_wr), .rd_ok(rok), .wr_ok(wok), .blocked(blk));

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic wreg(input logic [7:0] a, input logic [31:0] d, input logic s);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    see <= s;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
    #1;
  endtask : wreg

  task automatic rchk(input string n, input logic [7:0] a, input logic s,
    input logic [31:0] e);
    @(posedge ref_clk);
    addr <= a;
    see <= s;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 v = rdata;
    chk(n, e, v);
  endtask : rchk

  task automatic acc(input string n, input logic [7:0] a, input logic [2:0] e);
    logic [2:0] r;
    stg.access(a, r);
    chk(n, {29'h0, e}, {29'h0, r});
  endtask : acc

  // initialize length is fixed, but the wait is bounded rather than counted
  task automatic wait_re;
    i = 0;
    while (re_run !== 1'b1 && i < 20) begin
      @(posedge ref_clk);
      #1 i++;
    end
    chk("engine released", 32'h1, {31'h0, re_run});
  endtask : wait_re

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : wrap_up

  initial begin
    #100000;
    fail_count++;
    $display("[FAIL] run length expected finish seen timeout");
    wrap_up();
  end

  initial begin
    repeat (3) @(posedge ref_clk);
    #1 chk("outputs in reset", 32'h30, {26'h0, ov});
    @(posedge ref_clk);
    reset <= 1'b0;
    i = 0;
    while (see_act !== 1'b1 && i < 10) begin
      @(posedge ref_clk);
      #1 i++;
    end
    chk("secure env first", 32'h18, {26'h0, ov});
    @(posedge ref_clk);
    #1 chk("engine start", 32'h1C, {26'h0, ov});
    rchk("cause power-on", OFS_CAUSE, 1'b1, CAUSE_POR);
    rchk("cause hidden", OFS_CAUSE, 1'b0, 32'h0);
    rchk("unmapped", 8'hF0, 1'b1, 32'h0);
    $display("test reset done");

    wreg(OFS_CFG0, 32'h0001_1F10, 1'b1);
    wreg(OFS_CFG0 + OFS_CFG_STEP, 32'h0000_2718, 1'b1);
    acc("open before activate", 8'h1C, 3'b110);
    wreg(OFS_ACT, 32'h3, 1'b1);
    rchk("active flags", OFS_ACT, 1'b1, 32'h3);
    foreach (rows[k]) begin
      acc($sformatf("row %0d", k), rows[k].a, rows[k].exp);
    end
    wreg(OFS_ACT, 32'h0, 1'b1);
    rchk("clear attempt", OFS_ACT, 1'b1, 32'h3);
    wreg(OFS_CFG0 + OFS_CFG_STEP, 32'h0002_2F18, 1'b1);
    acc("grown region", 8'h2C, 3'b001);
    acc("grown mode", 8'h24, 3'b001);
    wreg(OFS_CFG0, 32'h0001_1F12, 1'b1);
    acc("shrink refused", 8'h10, 3'b101);
    wreg(OFS_CFG0, 32'h0003_1F10, 1'b1);
    rchk("mode 3 refused", OFS_CFG0, 1'b1, 32'h0001_1F10);
    $display("test latches done");

    wreg(OFS_CTRL, 32'h2, 1'b0);
    chk("bus masters from runtime", 32'h0, {31'h0, busm});
    wreg(OFS_CTRL, 32'h2, 1'b1);
    chk("bus masters from engine", 32'h1, {31'h0, busm});
    rchk("status", OFS_STATUS, 1'b1, 32'h72);
    wreg(OFS_STATUS, 32'h20, 1'b1);
    rchk("status cleared", OFS_STATUS, 1'b1, 32'h52);
    wreg(OFS_CTRL, 32'h3, 1'b0);
    chk("done from runtime", 32'h0, {31'h0, rt_run});
    wreg(OFS_CTRL, 32'h3, 1'b1);
    chk("runtime launch", 32'h0B, {26'h0, ov});
    $display("test launch done");

    @(posedge ref_clk);
    wdog <= 1'b1;
    @(posedge ref_clk);
    wdog <= 1'b0;
    #1 chk("watchdog reset", 32'h30, {26'h0, ov});
    wait_re();
    rchk("latches cleared", OFS_ACT, 1'b1, 32'h0);
    rchk("cause watchdog", OFS_CAUSE, 1'b1, CAUSE_WDOG);
    acc("open after init", 8'h12, 3'b110);
    $display("test watchdog done");

    wreg(OFS_CTRL, 32'h4, 1'b0);
    chk("reset from runtime", 32'h0, {31'h0, init_out});
    wreg(OFS_CTRL, 32'h4, 1'b1);
    chk("programmatic reset", 32'h1, {31'h0, init_out});
    wait_re();
    rchk("cause programmatic", OFS_CAUSE, 1'b1, CAUSE_PROG);
    $display("test software reset done");

    wreg(OFS_CTRL, 32'h1, 1'b1);
    chk("done without protect", 32'h0, {31'h0, rt_run});
    wreg(OFS_CFG0, 32'h0001_1F10, 1'b1);
    wreg(OFS_ACT, 32'h1, 1'b1);
    wreg(OFS_CTRL, 32'h1, 1'b1);
    chk("relaunch", 32'h1, {31'h0, rt_run});
    wreg(OFS_CTRL, 32'h4, 1'b0);
    chk("runtime reset request", 32'h1, {31'h0, init_out});
    wait_re();
    rchk("cause runtime request", OFS_CAUSE, 1'b1, CAUSE_PROG);
    $display("test runtime reset done");
    wrap_up();
  end
endmodule : mrpl_top_bench
